// file: core/cpu_interrupt_flag_bank_four.sv
// fourth cpu interrupt flag register: eight pending flags and a request vector
// assumes sources and vector acknowledges are one-cycle pulses on clk
//
// Local design decision: strobed register access.
`default_nettype none
module cpu_interrupt_flag_bank_four (
  input wire logic clk,
  input wire logic rst,
  input wire irq_flag_pkg::reg_req_type regReq,
  input wire irq_flag_pkg::flag_evt_type srcEvt,
  output logic [7:0] rdata,
  output logic [7:0] pendingReq
);
  // ************************************************************
  // address decode
  // ************************************************************
  logic hitReg;
  logic swWrite;
  logic readHit;
  logic [7:0] flags;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] pending_q;
  assign hitReg = (regReq.addr == irq_flag_pkg::FLAGS_FOUR_ADDR);
  assign swWrite = regReq.wr && hitReg;
  assign readHit = regReq.rd && hitReg;
  // unmapped reads answer zero, so a stray address never shows stale flags
  assign rdata_d = readHit ? flags : irq_flag_pkg::ZERO_BYTE;

  // ************************************************************
  // flag bits
  // ************************************************************
  // bit 6 is an ordinary storage bit: a written one is a live request,
  // which is why software must keep it clear
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      pending_flag_bit #(
        .HW_CLEAR(irq_flag_pkg::VECTOR_CLEAR_MASK[gi])
      ) u_bit (
        .clk(clk),
        .rst(rst),
        .setEvt(srcEvt.set[gi]),
        .vectorAck(srcEvt.vectorAck[gi]),
        .swWrite(swWrite),
        .swValue(regReq.wdata[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  // ************************************************************
  // field view
  // ************************************************************
  // named taps on each flag keep the checks below readable
  logic sleepTimerPending;
  logic portZeroPending;
  logic timerFourPending;
  logic timerThreePending;
  logic timerTwoPending;
  logic timerOnePending;
  logic transferDonePending;
  logic reservedFlag;
  assign sleepTimerPending = flags[irq_flag_pkg::SLEEP_TIMER_BIT];
  assign portZeroPending = flags[irq_flag_pkg::PORT_ZERO_BIT];
  assign timerFourPending = flags[irq_flag_pkg::TIMER_FOUR_BIT];
  assign timerThreePending = flags[irq_flag_pkg::TIMER_THREE_BIT];
  assign timerTwoPending = flags[irq_flag_pkg::TIMER_TWO_BIT];
  assign timerOnePending = flags[irq_flag_pkg::TIMER_ONE_BIT];
  assign transferDonePending = flags[irq_flag_pkg::TRANSFER_DONE_BIT];
  assign reservedFlag = flags[irq_flag_pkg::RESERVED_BIT];

  // ************************************************************
  // outputs
  // ************************************************************
  // read data stands for exactly the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= irq_flag_pkg::FLAGS_FOUR_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // request vector is the flag state itself, so a written one requests too;
  // the extra register costs a cycle of latency but keeps the output glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_q <= irq_flag_pkg::FLAGS_FOUR_RESET;
    end else begin
      pending_q <= flags;
    end
  end
  assign rdata = rdata_q;
  assign pendingReq = pending_q;

  // ************************************************************
  // checks
  // ************************************************************
  set_beats_write_a: assert property (@(posedge clk) disable iff (rst)
    swWrite && (srcEvt.set != irq_flag_pkg::ZERO_BYTE)
      |=> (flags & $past(srcEvt.set)) == $past(srcEvt.set))
    else $error("set lost to a same cycle write");
  sleep_set_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.set[irq_flag_pkg::SLEEP_TIMER_BIT] |=> ##1 pendingReq[irq_flag_pkg::SLEEP_TIMER_BIT])
    else $error("sleep timer request not shown");
  t4_clear_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.vectorAck[4] && !srcEvt.set[4] && !swWrite |=> !flags[4])
    else $error("timer four flag not cleared");
  t3_clear_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.vectorAck[3] && !srcEvt.set[3] && !swWrite |=> !flags[3])
    else $error("timer three flag not cleared");
  t2_set_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.set[2] |=> flags[2])
    else $error("timer two flag not set");
  t1_clear_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.vectorAck[1] && !srcEvt.set[1] && !swWrite |=> !flags[1])
    else $error("timer one flag not cleared");
  dma_hold_a: assert property (@(posedge clk) disable iff (rst)
    flags[0] && !swWrite |=> flags[0])
    else $error("transfer done flag dropped");
  sw_request_a: assert property (@(posedge clk) disable iff (rst)
    swWrite && regReq.wdata[5] |=> ##1 pendingReq[5])
    else $error("written flag gave no request");
  read_data_a: assert property (@(posedge clk) disable iff (rst)
    regReq.rd && hitReg |=> rdata == $past(flags))
    else $error("read data wrong");

  // ************************************************************
  // source sets
  // ************************************************************
  // every source pulse shows in its flag on the next edge; the flags
  // without a vector clear must hold whatever the core does
  port_set_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.set[irq_flag_pkg::PORT_ZERO_BIT] |=> portZeroPending)
    else $error("port zero flag not set");
  t4_set_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.set[irq_flag_pkg::TIMER_FOUR_BIT] |=> timerFourPending)
    else $error("timer four flag not set");
  t3_set_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.set[irq_flag_pkg::TIMER_THREE_BIT] |=> timerThreePending)
    else $error("timer three flag not set");
  t1_set_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.set[irq_flag_pkg::TIMER_ONE_BIT] |=> timerOnePending)
    else $error("timer one flag not set");
  dma_set_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.set[irq_flag_pkg::TRANSFER_DONE_BIT] |=> transferDonePending)
    else $error("transfer done flag not set");
  sleep_hold_a: assert property (@(posedge clk) disable iff (rst)
    sleepTimerPending && !swWrite |=> sleepTimerPending)
    else $error("sleep timer flag dropped");
  port_hold_a: assert property (@(posedge clk) disable iff (rst)
    portZeroPending && !swWrite |=> portZeroPending)
    else $error("port zero flag dropped");

  // ************************************************************
  // vector clears
  // ************************************************************
  // a vector acknowledge clears a timer flag and, one edge later,
  // withdraws its request unless a set or a write lands beside it
  t2_clear_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.vectorAck[irq_flag_pkg::TIMER_TWO_BIT] && !srcEvt.set[irq_flag_pkg::TIMER_TWO_BIT]
      && !swWrite |=> !timerTwoPending)
    else $error("timer two flag not cleared");
  t4_withdraw_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.vectorAck[irq_flag_pkg::TIMER_FOUR_BIT] && !srcEvt.set[irq_flag_pkg::TIMER_FOUR_BIT]
      && !swWrite |=> ##1 !pendingReq[irq_flag_pkg::TIMER_FOUR_BIT])
    else $error("timer four request not withdrawn");
  t3_withdraw_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.vectorAck[irq_flag_pkg::TIMER_THREE_BIT] && !srcEvt.set[irq_flag_pkg::TIMER_THREE_BIT]
      && !swWrite |=> ##1 !pendingReq[irq_flag_pkg::TIMER_THREE_BIT])
    else $error("timer three request not withdrawn");
  t2_withdraw_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.vectorAck[irq_flag_pkg::TIMER_TWO_BIT] && !srcEvt.set[irq_flag_pkg::TIMER_TWO_BIT]
      && !swWrite |=> ##1 !pendingReq[irq_flag_pkg::TIMER_TWO_BIT])
    else $error("timer two request not withdrawn");
  t1_withdraw_a: assert property (@(posedge clk) disable iff (rst)
    srcEvt.vectorAck[irq_flag_pkg::TIMER_ONE_BIT] && !srcEvt.set[irq_flag_pkg::TIMER_ONE_BIT]
      && !swWrite |=> ##1 !pendingReq[irq_flag_pkg::TIMER_ONE_BIT])
    else $error("timer one request not withdrawn");

  // ************************************************************
  // software port
  // ************************************************************
  // a write replaces the whole byte when no source fires beside it;
  // the reserved bit moves only on a write or its own set pulse, and the write is the user's hazard
  dma_request_a: assert property (@(posedge clk) disable iff (rst)
    swWrite && regReq.wdata[irq_flag_pkg::TRANSFER_DONE_BIT]
      |=> ##1 pendingReq[irq_flag_pkg::TRANSFER_DONE_BIT])
    else $error("written transfer flag gave no request");
  write_lands_a: assert property (@(posedge clk) disable iff (rst)
    swWrite && (srcEvt.set == irq_flag_pkg::ZERO_BYTE) |=> flags == $past(regReq.wdata))
    else $error("written byte not stored");
  reserved_hold_a: assert property (@(posedge clk) disable iff (rst)
    !swWrite && !srcEvt.set[irq_flag_pkg::RESERVED_BIT] |=> $stable(reservedFlag))
    else $error("reserved bit moved without a write");
  read_sleep_a: assert property (@(posedge clk) disable iff (rst)
    readHit && sleepTimerPending |=> rdata[irq_flag_pkg::SLEEP_TIMER_BIT])
    else $error("pending sleep timer flag read as zero");
  read_dma_a: assert property (@(posedge clk) disable iff (rst)
    readHit && transferDonePending |=> rdata[irq_flag_pkg::TRANSFER_DONE_BIT])
    else $error("pending transfer flag read as zero");
  rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
    !regReq.rd |=> rdata == irq_flag_pkg::ZERO_BYTE)
    else $error("read data outside a read");
  unmapped_zero_a: assert property (@(posedge clk) disable iff (rst)
    regReq.rd && !hitReg |=> rdata == irq_flag_pkg::ZERO_BYTE)
    else $error("unmapped read not zero");

  // ************************************************************
  // reset
  // ************************************************************
  // reset is synchronous, so these checks run without a disable clause
  reset_flags_a: assert property (@(posedge clk)
    rst |=> flags == irq_flag_pkg::FLAGS_FOUR_RESET)
    else $error("flags not cleared by reset");
  reset_request_a: assert property (@(posedge clk)
    rst |=> pendingReq == irq_flag_pkg::FLAGS_FOUR_RESET)
    else $error("requests not cleared by reset");
  reset_rdata_a: assert property (@(posedge clk)
    rst |=> rdata == irq_flag_pkg::ZERO_BYTE)
    else $error("read data not cleared by reset");
endmodule
`default_nettype wire

// file: core/irq_flag_pkg.sv
// constants and carrier types for the fourth cpu interrupt flag register
// assumes a single 50 MHz clock domain and a plain register port
`default_nettype none
package irq_flag_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] FLAGS_FOUR_ADDR = 8'hc0;
  localparam logic [7:0] FLAGS_FOUR_RESET = 8'h00;
  // field positions
  localparam int SLEEP_TIMER_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int PORT_ZERO_BIT = 5;
  localparam int TIMER_FOUR_BIT = 4;
  localparam int TIMER_THREE_BIT = 3;
  localparam int TIMER_TWO_BIT = 2;
  localparam int TIMER_ONE_BIT = 1;
  localparam int TRANSFER_DONE_BIT = 0;
  // bits that hardware clears when the core vectors to their routine
  localparam logic [7:0] VECTOR_CLEAR_MASK = 8'h1e;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // per-bit source events, one-cycle pulses, laid out as the register
  typedef struct packed {
    logic [7:0] set;
    logic [7:0] vectorAck;
  } flag_evt_type;
endpackage
`default_nettype wire

// file: core/pending_flag_bit.sv
// one sticky pending flag with hardware set, vector clear and software write
// assumes all inputs synchronous to clk
`default_nettype none
module pending_flag_bit #(
  parameter bit HW_CLEAR = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic setEvt,
  input wire logic vectorAck,
  input wire logic swWrite,
  input wire logic swValue,
  output logic flag
);
  logic flag_q;
  logic flag_d;
  // set beats both clears so a request is never lost
  assign flag_d = setEvt ? 1'b1 :
                  swWrite ? swValue :
                  (HW_CLEAR && vectorAck) ? 1'b0 : flag_q;
  assign flag = flag_q;
  // ************************************************************
  // storage
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule
`default_nettype wire

// file: testbench/irq_far_side.sv
// far side model: peripheral sources and the core's vectoring logic
// assumes one clock; every event is a one-cycle pulse
`default_nettype none
module irq_far_side (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] fire,
  input wire logic autoVector,
  input wire logic [7:0] pendingReq,
  output var irq_flag_pkg::flag_evt_type srcEvt
);
  timeunit 1ns;
  timeprecision 1ns;
  // bit 6 has no source and is never raised; the core vectors to every
  // pending routine, and the block must ignore that on non-timer flags
  always_ff @(posedge clk) begin
    if (rst) begin
      srcEvt <= '0;
    end else begin
      srcEvt.set <= fire & 8'hbf;
      srcEvt.vectorAck <= autoVector ? pendingReq & ~srcEvt.vectorAck : 8'h00;
    end
  end
endmodule
`default_nettype wire

// file: testbench/cpu_interrupt_flag_bank_four_test.sv
// bench for the fourth interrupt flag register
// assumes the far side model makes every source event
`default_nettype none
module cpu_interrupt_flag_bank_four_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, autoVector = 1'b0;
  logic [7:0] fire = 8'h00, rdata, pendingReq;
  int nErrors = 0, totalChecks = 0, cyc = 0;
  irq_flag_pkg::reg_req_type regReq = '0;
  irq_flag_pkg::flag_evt_type srcEvt;
  always #10 clk = ~clk;
  cpu_interrupt_flag_bank_four dut (.clk(clk), .rst(rst), .regReq(regReq),
    .srcEvt(srcEvt), .rdata(rdata), .pendingReq(pendingReq));
  irq_far_side far (.clk(clk), .rst(rst), .fire(fire), .autoVector(autoVector),
    .pendingReq(pendingReq), .srcEvt(srcEvt));
  task automatic chk(input logic [7:0] got, exp);
    totalChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) regReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk) regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) regReq.rd <= 1'b0;
    @(negedge clk) chk(rdata, e);
    @(negedge clk) chk(rdata, 8'h00); // read data stands one cycle only
  endtask
  // software set flags must request service just like hardware ones
  task automatic swFlags;
    wr(8'hc0, 8'ha1);
    rd(8'hc0, 8'ha1);
    chk(pendingReq, 8'ha1);
    wr(8'hc0, 8'h00);
    rd(8'hc0, 8'h00);
    $display("swFlags done");
  endtask
  task automatic hwFlags;
    @(posedge clk) fire <= 8'hbf;
    @(posedge clk) fire <= 8'h00;
    @(posedge clk);
    @(negedge clk) chk(pendingReq, 8'h00);
    rd(8'hc0, 8'hbf);
    chk(pendingReq, 8'hbf);
    $display("hwFlags done");
  endtask
  // only the timer flags may drop when the core vectors
  task automatic vecClear;
    @(posedge clk) autoVector <= 1'b1;
    repeat (6) @(posedge clk);
    autoVector <= 1'b0;
    rd(8'hc0, 8'ha1);
    $display("vecClear done");
  endtask
  // a source pulse lands in the same cycle as a clearing write
  task automatic race;
    @(posedge clk) fire <= 8'h80;
    @(posedge clk) fire <= 8'h00;
    regReq <= '{8'hc0, 8'h00, 1'b1, 1'b0};
    @(posedge clk) regReq.wr <= 1'b0;
    rd(8'hc0, 8'h80);
    $display("race done");
  endtask
  task automatic unmapped;
    wr(8'hc1, 8'hff);
    rd(8'hc0, 8'h80);
    rd(8'hc1, 8'h00);
    $display("unmapped done");
  endtask
  // a reset in mid run must drop every flag and request
  task automatic midReset;
    wr(8'hc0, 8'ha1);
    rd(8'hc0, 8'ha1);
    chk(pendingReq, 8'ha1);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'hc0, 8'h00);
    chk(pendingReq, 8'h00);
    $display("midReset done");
  endtask
  task automatic results;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'hc0, 8'h00);
    swFlags();
    hwFlags();
    vecClear();
    race();
    unmapped();
    midReset();
    results();
  end
  // a hang is cut short well past the sixty or so cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      nErrors++;
      results();
    end
  end
endmodule
`default_nettype wire
